// ### cos_pkg.sv
// constants for the color offset register select block
// assumes a 32-bit ahb-lite register bus with one register per aligned word
package cos_pkg;

    // --------------------------------------------------------------
    // register indices (byte address is four times the index)
    // --------------------------------------------------------------
    localparam int         IDX_W         = 5;
    localparam logic [4:0] IDX_C3_DAC_HI = 5'h09;
    localparam logic [4:0] IDX_C3_DAC_LO = 5'h0A;
    localparam logic [4:0] IDX_C4_DAC_HI = 5'h0B;
    localparam logic [4:0] IDX_C4_DAC_LO = 5'h0C;
    localparam logic [4:0] IDX_C5_DAC_HI = 5'h0D;
    localparam logic [4:0] IDX_C5_DAC_LO = 5'h0E;
    localparam logic [4:0] IDX_C1_DOFS   = 5'h0F;
    localparam logic [4:0] IDX_C2_DOFS   = 5'h10;
    localparam logic [4:0] IDX_C3_DOFS   = 5'h11;
    localparam logic [4:0] IDX_C4_DOFS   = 5'h12;
    localparam logic [4:0] IDX_MODE      = 5'h14;
    localparam logic [4:0] IDX_STATUS    = 5'h15;
    localparam logic [4:0] IDX_PAGE      = 5'h1F;
    localparam int         CFG_FIRST     = 9;
    localparam int         CFG_COUNT     = 10;

    // --------------------------------------------------------------
    // reset values and page
    // --------------------------------------------------------------
    localparam logic [7:0] RST_DAC_HI    = 8'h80;
    localparam logic [7:0] RST_DAC_LO    = 8'h00;
    localparam logic [7:0] RST_DOFS      = 8'h40;
    localparam logic [7:0] RST_PAGE      = 8'h00;
    localparam logic [1:0] RST_MODE      = 2'h0;
    localparam logic [7:0] PAGE_THIS     = 8'h01;

    // --------------------------------------------------------------
    // field layouts
    // --------------------------------------------------------------
    localparam int         DAC_LO_W      = 2;
    localparam int         DAC_W         = 10;
    localparam int         DOFS_W        = 7;
    localparam int         MODE_W        = 2;
    localparam int         STAT_DAC_LSB  = 16;
    localparam logic [9:0] MID_DAC       = 10'h200;
    localparam logic [6:0] MID_DOFS      = 7'h40;
    localparam int         NUM_COLORS    = 5;

    typedef enum logic [1:0] {
        MODE_LINE_SEQUENTIAL_COLOR = 2'b00,
        MODE_SINGLE_CHANNEL_FIXED  = 2'b01,
        MODE_TWO                   = 2'b10,
        MODE_THREE                 = 2'b11
    } cos_mode_e;

endpackage

// ### cos_ahb_port.sv
// ahb-lite slave front end: decodes word accesses into index strobes
// assumes single whole-word transfers; answers with zero wait states
`timescale 1ns/1ns
module cos_ahb_port (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // register side
    output logic             wr_en,
    output logic      [4:0]  wr_idx,
    output logic      [31:0] wr_data,
    output logic      [4:0]  rd_idx,
    input  wire logic [31:0] rd_data
);

    logic        take;
    logic        addr_ok;
    logic        wr_pend_reg, wr_pend_next;
    logic [4:0]  wr_idx_reg,  wr_idx_next;
    logic [31:0] hrdata_reg,  hrdata_next;

    // --------------------------------------------------------------
    // address phase capture
    // --------------------------------------------------------------
    always_comb begin
        take         = hsel && htrans[1] && hready;
        addr_ok      = (haddr[31:7] == 25'h0000000) && (haddr[1:0] == 2'h0) && (hsize == 3'h2);
        rd_idx       = haddr[6:2];
        wr_pend_next = take && hwrite && addr_ok;
        wr_idx_next  = wr_pend_next ? haddr[6:2] : wr_idx_reg;
        hrdata_next  = (take && !hwrite && addr_ok) ? rd_data : 32'h00000000;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg  <= 5'h00;
            hrdata_reg  <= 32'h00000000;
        end else begin
            wr_pend_reg <= wr_pend_next;
            wr_idx_reg  <= wr_idx_next;
            hrdata_reg  <= hrdata_next;
        end
    end

    assign wr_en     = wr_pend_reg;
    assign wr_idx    = wr_idx_reg;
    assign wr_data   = hwdata;
    assign hrdata    = hrdata_reg;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

endmodule

// ### cos_color_sel.sv
// five-way selector of offset words by line color
// assumes color codes 1 to 5; any other code selects midscale
`timescale 1ns/1ns
module cos_color_sel (
    // selection
    input  wire logic [2:0]                 color,
    // candidates, color 1 in slot 0
    input  wire logic [4:0][cos_pkg::DAC_W-1:0]  dac_codes,
    input  wire logic [4:0][cos_pkg::DOFS_W-1:0] dofs_words,
    // result
    output logic      [cos_pkg::DAC_W-1:0]  dac_code,
    output logic      [cos_pkg::DOFS_W-1:0] dofs_word
);

    // maps a color code to its slot, or -1 when out of range
    function automatic int slot_of(input logic [2:0] c);
        if (c >= 3'h1 && c <= 3'h5) begin
            return int'(c) - 1;
        end
        return -1;
    endfunction

    always_comb begin
        dac_code  = cos_pkg::MID_DAC;
        dofs_word = cos_pkg::MID_DOFS;
        if (slot_of(color) >= 0) begin
            dac_code  = dac_codes[slot_of(color)];
            dofs_word = dofs_words[slot_of(color)];
        end
    end

endmodule

// ### cos_top.sv
// color offset register bank with line-color selection
// assumes line_color is synchronous to hclk and stable through a line;
// color 1 and 2 dac words and color 5 digital offset come from elsewhere
`timescale 1ns/1ns

module cos_top (
    // clock and reset
    input  wire logic                        hclk,
    input  wire logic                        hresetn,
    // ahb-lite slave
    input  wire logic                        hsel,
    input  wire logic [31:0]                 haddr,
    input  wire logic [1:0]                  htrans,
    input  wire logic                        hwrite,
    input  wire logic [2:0]                  hsize,
    input  wire logic                        hready,
    input  wire logic [31:0]                 hwdata,
    output logic      [31:0]                 hrdata,
    output logic                             hreadyout,
    output logic                             hresp,
    // line color and words held elsewhere
    input  wire logic [2:0]                  line_color,
    input  wire logic [cos_pkg::DAC_W-1:0]   color1_dac_code,
    input  wire logic [cos_pkg::DAC_W-1:0]   color2_dac_code,
    input  wire logic [cos_pkg::DOFS_W-1:0]  color5_dofs,
    // line-sequential selection
    output logic      [cos_pkg::DAC_W-1:0]   line_dac_code,
    output logic      [cos_pkg::DOFS_W-1:0]  line_dofs,
    // fixed channel settings
    output logic      [cos_pkg::DAC_W-1:0]   blue_dac_code,
    output logic      [cos_pkg::DOFS_W-1:0]  red_dofs,
    output logic      [cos_pkg::DOFS_W-1:0]  green_dofs,
    output logic      [cos_pkg::DOFS_W-1:0]  blue_dofs
);

    // --------------------------------------------------------------
    // declarations
    // --------------------------------------------------------------
    localparam int N = cos_pkg::CFG_COUNT;

    logic                           wr_en;
    logic [4:0]                     wr_idx;
    logic [31:0]                    wr_data;
    logic [4:0]                     rd_idx;
    logic [31:0]                    rd_data;
    logic                           page_hit;

    logic [7:0]                     cfg_reg [0:N-1];
    logic [7:0]                     cfg_next [0:N-1];
    logic [7:0]                     page_reg, page_next;
    cos_pkg::cos_mode_e             mode_reg, mode_next;

    logic [4:0][cos_pkg::DAC_W-1:0]  dac_cand;
    logic [4:0][cos_pkg::DOFS_W-1:0] dofs_cand;
    logic [cos_pkg::DAC_W-1:0]      sel_dac;
    logic [cos_pkg::DOFS_W-1:0]     sel_dofs;

    logic [cos_pkg::DAC_W-1:0]      line_dac_reg,  line_dac_next;
    logic [cos_pkg::DOFS_W-1:0]     line_dofs_reg, line_dofs_next;
    logic [cos_pkg::DAC_W-1:0]      blue_dac_reg,  blue_dac_next;
    logic [cos_pkg::DOFS_W-1:0]     red_dofs_reg,  red_dofs_next;
    logic [cos_pkg::DOFS_W-1:0]     green_dofs_reg, green_dofs_next;
    logic [cos_pkg::DOFS_W-1:0]     blue_dofs_reg, blue_dofs_next;

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    // reset value of a page register by its slot
    function automatic logic [7:0] cfg_reset(input int slot);
        logic [4:0] idx;
        idx = 5'(slot + cos_pkg::CFG_FIRST);
        if (idx >= cos_pkg::IDX_C1_DOFS) begin
            return cos_pkg::RST_DOFS;
        end
        if (idx[0]) begin
            return cos_pkg::RST_DAC_HI;
        end
        return cos_pkg::RST_DAC_LO;
    endfunction

    // slot of a page register index, -1 when not held here
    function automatic int cfg_slot(input logic [4:0] idx);
        if (idx >= cos_pkg::IDX_C3_DAC_HI && idx <= cos_pkg::IDX_C4_DOFS) begin
            return int'(idx) - cos_pkg::CFG_FIRST;
        end
        return -1;
    endfunction

    // ten-bit code from a high byte and a low byte
    function automatic logic [9:0] dac_join(input logic [7:0] hi, input logic [7:0] lo);
        return {hi, lo[cos_pkg::DAC_LO_W-1:0]};
    endfunction

    // --------------------------------------------------------------
    // bus front end
    // --------------------------------------------------------------
    cos_ahb_port u_port (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hready    (hready),
        .hwdata    (hwdata),
        .hrdata    (hrdata),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .wr_en     (wr_en),
        .wr_idx    (wr_idx),
        .wr_data   (wr_data),
        .rd_idx    (rd_idx),
        .rd_data   (rd_data)
    );

    // --------------------------------------------------------------
    // register writes
    // --------------------------------------------------------------
    always_comb begin
        page_hit  = (page_reg == cos_pkg::PAGE_THIS);
        page_next = page_reg;
        mode_next = mode_reg;
        for (int i = 0; i < N; i++) begin
            cfg_next[i] = cfg_reg[i];
        end
        if (wr_en) begin
            if (wr_idx == cos_pkg::IDX_PAGE) begin
                page_next = wr_data[7:0];
            end else if (page_hit && wr_idx == cos_pkg::IDX_MODE) begin
                mode_next = cos_pkg::cos_mode_e'(wr_data[cos_pkg::MODE_W-1:0]);
            end else if (page_hit && cfg_slot(wr_idx) >= 0) begin
                cfg_next[cfg_slot(wr_idx)] = wr_data[7:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            page_reg <= cos_pkg::RST_PAGE;
            mode_reg <= cos_pkg::MODE_LINE_SEQUENTIAL_COLOR;
            for (int i = 0; i < N; i++) begin
                cfg_reg[i] <= cfg_reset(i);
            end
        end else begin
            page_reg <= page_next;
            mode_reg <= mode_next;
            for (int i = 0; i < N; i++) begin
                cfg_reg[i] <= cfg_next[i];
            end
        end
    end

    // --------------------------------------------------------------
    // register reads
    // --------------------------------------------------------------
    // read page, mode and page words from next values so a write in its data phase is seen at once; status reads the output registers
    always_comb begin
        rd_data = 32'h00000000;
        if (rd_idx == cos_pkg::IDX_PAGE) begin
            rd_data[7:0] = page_next;
        end else if (page_hit && rd_idx == cos_pkg::IDX_MODE) begin
            rd_data[cos_pkg::MODE_W-1:0] = mode_next;
        end else if (page_hit && rd_idx == cos_pkg::IDX_STATUS) begin
            rd_data[cos_pkg::STAT_DAC_LSB +: cos_pkg::DAC_W] = line_dac_reg;
            rd_data[cos_pkg::DOFS_W-1:0] = line_dofs_reg;
        end else if (page_hit && cfg_slot(rd_idx) >= 0) begin
            rd_data[7:0] = cfg_next[cfg_slot(rd_idx)];
        end
    end

    // --------------------------------------------------------------
    // five-way selection by line color
    // --------------------------------------------------------------
    always_comb begin
        dac_cand[0]  = color1_dac_code;
        dac_cand[1]  = color2_dac_code;
        dac_cand[2]  = dac_join(cfg_reg[0], cfg_reg[1]);
        dac_cand[3]  = dac_join(cfg_reg[2], cfg_reg[3]);
        dac_cand[4]  = dac_join(cfg_reg[4], cfg_reg[5]);
        dofs_cand[0] = cfg_reg[6][cos_pkg::DOFS_W-1:0];
        dofs_cand[1] = cfg_reg[7][cos_pkg::DOFS_W-1:0];
        dofs_cand[2] = cfg_reg[8][cos_pkg::DOFS_W-1:0];
        dofs_cand[3] = cfg_reg[9][cos_pkg::DOFS_W-1:0];
        dofs_cand[4] = color5_dofs;
    end

    cos_color_sel u_sel (
        .color      (line_color),
        .dac_codes  (dac_cand),
        .dofs_words (dofs_cand),
        .dac_code   (sel_dac),
        .dofs_word  (sel_dofs)
    );

    // --------------------------------------------------------------
    // active settings
    // --------------------------------------------------------------
    // midscale means no correction, so idle outputs rest there
    always_comb begin
        line_dac_next   = cos_pkg::MID_DAC;
        line_dofs_next  = cos_pkg::MID_DOFS;
        blue_dac_next   = cos_pkg::MID_DAC;
        red_dofs_next   = cos_pkg::MID_DOFS;
        green_dofs_next = cos_pkg::MID_DOFS;
        blue_dofs_next  = cos_pkg::MID_DOFS;
        unique case (mode_reg)
            cos_pkg::MODE_LINE_SEQUENTIAL_COLOR: begin
                line_dac_next  = sel_dac;
                line_dofs_next = sel_dofs;
            end
            cos_pkg::MODE_SINGLE_CHANNEL_FIXED,
            cos_pkg::MODE_TWO,
            cos_pkg::MODE_THREE: begin
                // color 4 and 5 words are not consulted here
                blue_dac_next   = dac_cand[2];
                red_dofs_next   = dofs_cand[0];
                green_dofs_next = dofs_cand[1];
                blue_dofs_next  = dofs_cand[2];
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            line_dac_reg   <= cos_pkg::MID_DAC;
            line_dofs_reg  <= cos_pkg::MID_DOFS;
            blue_dac_reg   <= cos_pkg::MID_DAC;
            red_dofs_reg   <= cos_pkg::MID_DOFS;
            green_dofs_reg <= cos_pkg::MID_DOFS;
            blue_dofs_reg  <= cos_pkg::MID_DOFS;
        end else begin
            line_dac_reg   <= line_dac_next;
            line_dofs_reg  <= line_dofs_next;
            blue_dac_reg   <= blue_dac_next;
            red_dofs_reg   <= red_dofs_next;
            green_dofs_reg <= green_dofs_next;
            blue_dofs_reg  <= blue_dofs_next;
        end
    end

    assign line_dac_code = line_dac_reg;
    assign line_dofs     = line_dofs_reg;
    assign blue_dac_code = blue_dac_reg;
    assign red_dofs      = red_dofs_reg;
    assign green_dofs    = green_dofs_reg;
    assign blue_dofs     = blue_dofs_reg;

endmodule

// ### cos_top_checker.sv
// concurrent checks on the ports of the color offset register bank
// assumes it is bound to cos_top and sees only that module's ports
`timescale 1ns/1ns
module cos_top_checker (
    // clock and reset
    input wire logic                       hclk,
    input wire logic                       hresetn,
    // ahb-lite slave
    input wire logic                       hsel,
    input wire logic [31:0]                haddr,
    input wire logic [1:0]                 htrans,
    input wire logic                       hwrite,
    input wire logic [2:0]                 hsize,
    input wire logic                       hready,
    input wire logic [31:0]                hwdata,
    input wire logic [31:0]                hrdata,
    input wire logic                       hreadyout,
    input wire logic                       hresp,
    // line color and outside words
    input wire logic [2:0]                 line_color,
    input wire logic [cos_pkg::DAC_W-1:0]  color1_dac_code,
    input wire logic [cos_pkg::DAC_W-1:0]  color2_dac_code,
    input wire logic [cos_pkg::DOFS_W-1:0] color5_dofs,
    // selected and fixed outputs
    input wire logic [cos_pkg::DAC_W-1:0]  line_dac_code,
    input wire logic [cos_pkg::DOFS_W-1:0] line_dofs,
    input wire logic [cos_pkg::DAC_W-1:0]  blue_dac_code,
    input wire logic [cos_pkg::DOFS_W-1:0] red_dofs,
    input wire logic [cos_pkg::DOFS_W-1:0] green_dofs,
    input wire logic [cos_pkg::DOFS_W-1:0] blue_dofs
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // ----------------------------------------------------------
    // bus and selection checks
    // ----------------------------------------------------------
    sequence rd_addr_s;
        hsel && htrans[1] && hready && !hwrite;
    endsequence
    // three edges with no write and steady selection inputs
    sequence quiet_s;
        (!(hsel && htrans[1] && hwrite) && $stable(line_color) && $stable(color1_dac_code)
            && $stable(color2_dac_code) && $stable(color5_dofs)) [*3];
    endsequence

    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answered with wait or error");
    a_idle_rdata: assert property (!(hsel && htrans[1] && hready && !hwrite) |=> hrdata == 32'h0)
        else $error("read data outside a read data phase");
    a_unmapped_zero: assert property ((rd_addr_s ##0 haddr[31:7] != 25'h0) |=> hrdata == 32'h0)
        else $error("unmapped read returned data");
    a_upper_zero: assert property ((rd_addr_s ##0 haddr[6:2] != cos_pkg::IDX_STATUS)
        |=> hrdata[31:8] == 24'h0)
        else $error("byte register read with upper bits set");
    a_bad_color: assert property (!(line_color inside {[3'd1:3'd5]})
        |=> line_dac_code == cos_pkg::MID_DAC && line_dofs == cos_pkg::MID_DOFS)
        else $error("invalid color did not select midscale");
    a_fixed_excl: assert property ((red_dofs != cos_pkg::MID_DOFS || green_dofs != cos_pkg::MID_DOFS
        || blue_dofs != cos_pkg::MID_DOFS || blue_dac_code != cos_pkg::MID_DAC)
        |-> line_dac_code == cos_pkg::MID_DAC && line_dofs == cos_pkg::MID_DOFS)
        else $error("line and fixed settings active together");
    a_reset_mid: assert property ($rose(hresetn) |-> line_dac_code == cos_pkg::MID_DAC
        && red_dofs == cos_pkg::MID_DOFS && blue_dac_code == cos_pkg::MID_DAC)
        else $error("outputs not at midscale after reset");
    a_c5_follow: assert property ((line_color == 3'd5 && $stable(line_color) && $stable(color5_dofs)
        && line_dofs != cos_pkg::MID_DOFS)
        |=> (line_dofs == $past(color5_dofs) || line_dofs == cos_pkg::MID_DOFS))
        else $error("color 5 offset not followed");
    a_quiet_hold: assert property (quiet_s |=> $stable(line_dac_code) && $stable(line_dofs)
        && $stable(blue_dac_code) && $stable(red_dofs))
        else $error("outputs moved with no cause");
endmodule

bind cos_top cos_top_checker cos_top_checker_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hready, .hwdata, .hrdata, .hreadyout, .hresp, .line_color, .color1_dac_code,
    .color2_dac_code, .color5_dofs, .line_dac_code, .line_dofs, .blue_dac_code, .red_dofs,
    .green_dofs, .blue_dofs);

// ### test_color_offset_register_select.sv
// self-checking bench for the color offset register bank
// assumes cos_top with its checker bound; drives ahb-lite and line color
`timescale 1ns/1ns
module test_color_offset_register_select;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize, line_color;
    logic [9:0]  color1_dac_code, color2_dac_code, line_dac_code, blue_dac_code;
    logic [6:0]  color5_dofs, line_dofs, red_dofs, green_dofs, blue_dofs;
    logic [7:0]  vals [10] = '{8'h3C, 8'hFD, 8'hC1, 8'hFE, 8'h07, 8'h03, 8'h81, 8'h7F, 8'h15, 8'hAA};
    logic [9:0]  edac [1:5];
    logic [6:0]  edofs [1:5];
    int          err_count = 0;
    int          checks = 0;

    assign hready = hreadyout;

    cos_top cos_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .line_color(line_color), .color1_dac_code(color1_dac_code),
        .color2_dac_code(color2_dac_code), .color5_dofs(color5_dofs), .line_dac_code(line_dac_code),
        .line_dofs(line_dofs), .blue_dac_code(blue_dac_code), .red_dofs(red_dofs),
        .green_dofs(green_dofs), .blue_dofs(blue_dofs));

    // ----------------------------------------------------------
    // helpers
    // ----------------------------------------------------------
    function automatic logic [31:0] addr(input logic [4:0] idx);
        return {25'h0, idx, 2'b00};
    endfunction
    function automatic logic [9:0] dac(input logic [7:0] hi, input logic [7:0] lo);
        return {hi, lo[1:0]};
    endfunction
    task automatic check_bus(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: bus read %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic check_out(input logic [9:0] got, input logic [9:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: output %h, expected %h", $time, got, exp);
        end
    endtask
    // one whole-word transfer, entered just after a rising edge
    task automatic bus(input logic [31:0] a, input logic wr, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        hsize <= 3'b010;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] rd;
        bus(a, 1'b1, d, rd);
    endtask
    task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        bus(a, 1'b0, 32'h0, rd);
        check_bus(rd, exp);
    endtask
    task automatic end_of_test;
        $display("comparisons %0d, mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------
    // clock and watchdog
    // ----------------------------------------------------------
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    initial begin
        repeat (5000) @(posedge hclk);
        err_count++;
        end_of_test();
    end

    // ----------------------------------------------------------
    // tests
    // ----------------------------------------------------------
    initial begin
        logic [7:0] exp8;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        line_color = 3'h0;
        color1_dac_code = 10'h155;
        color2_dac_code = 10'h2AA;
        color5_dofs = 7'h11;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check_out(line_dac_code, cos_pkg::MID_DAC);
        check_out({3'h0, line_dofs}, {3'h0, cos_pkg::MID_DOFS});
        check_out(blue_dac_code, cos_pkg::MID_DAC);
        check_out({3'h0, red_dofs}, {3'h0, cos_pkg::MID_DOFS});
        rdc(addr(cos_pkg::IDX_PAGE), 32'h0);
        wr(addr(cos_pkg::IDX_C3_DAC_HI), 32'h55);
        rdc(addr(cos_pkg::IDX_C3_DAC_HI), 32'h0);
        wr(addr(cos_pkg::IDX_PAGE), {24'h0, cos_pkg::PAGE_THIS});
        rdc(addr(cos_pkg::IDX_PAGE), {24'h0, cos_pkg::PAGE_THIS});
        for (int i = 0; i < cos_pkg::CFG_COUNT; i++) begin
            exp8 = (i >= 6) ? cos_pkg::RST_DOFS : (i[0] ? cos_pkg::RST_DAC_LO : cos_pkg::RST_DAC_HI);
            rdc(addr(5'(cos_pkg::CFG_FIRST + i)), {24'h0, exp8});
        end
        $display("test reset done");
        for (int i = 0; i < cos_pkg::CFG_COUNT; i++) begin
            wr(addr(5'(cos_pkg::CFG_FIRST + i)), {24'h0, vals[i]});
        end
        for (int i = 0; i < cos_pkg::CFG_COUNT; i++) begin
            rdc(addr(5'(cos_pkg::CFG_FIRST + i)), {24'h0, vals[i]});
        end
        rdc(32'h0000_0060, 32'h0);
        rdc(32'h0000_00A4, 32'h0);
        $display("test readback done");
        edac = '{color1_dac_code, color2_dac_code, dac(vals[0], vals[1]), dac(vals[2], vals[3]),
                 dac(vals[4], vals[5])};
        edofs = '{vals[6][6:0], vals[7][6:0], vals[8][6:0], vals[9][6:0], color5_dofs};
        for (int c = 1; c <= cos_pkg::NUM_COLORS; c++) begin
            line_color <= 3'(c);
            repeat (3) @(posedge hclk);
            check_out(line_dac_code, edac[c]);
            check_out({3'h0, line_dofs}, {3'h0, edofs[c]});
            check_out(blue_dac_code, cos_pkg::MID_DAC);
            if (c == 4) rdc(addr(cos_pkg::IDX_STATUS), {6'h0, edac[4], 9'h0, edofs[4]});
        end
        $display("test line colors done");
        line_color <= 3'h4;
        for (int m = 1; m < 4; m++) begin
            wr(addr(cos_pkg::IDX_MODE), 32'(m));
            rdc(addr(cos_pkg::IDX_MODE), 32'(m));
            repeat (3) @(posedge hclk);
            check_out(blue_dac_code, dac(vals[0], vals[1]));
            check_out({3'h0, red_dofs}, {3'h0, vals[6][6:0]});
            check_out({3'h0, green_dofs}, {3'h0, vals[7][6:0]});
            check_out({3'h0, blue_dofs}, {3'h0, vals[8][6:0]});
            check_out(line_dac_code, cos_pkg::MID_DAC);
            check_out({3'h0, line_dofs}, {3'h0, cos_pkg::MID_DOFS});
        end
        $display("test fixed modes done");
        end_of_test();
    end
endmodule
